// ===== pkg/cs_decode_pkg.sv
// Constants, field layout and register map of the chip-select decode block
package cs_decode_pkg;
	// ------------------------------------------------------------
	// Register map (byte offsets on the plain register port)
	// ------------------------------------------------------------
	localparam int NUM_BANKS = 7;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ORIGIN_BASE = 8'h80;
	localparam logic [7:0] BANK_STRIDE = 8'h0C;
	localparam logic [7:0] MASK_OFS = 8'h04;
	localparam logic [7:0] CONTROL_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'hE0;

	// ------------------------------------------------------------
	// Mask register fields
	// ------------------------------------------------------------
	localparam int IGN_LSB = 16;
	localparam int IGN_W = 16;
	localparam int WP_BIT = 8;
	localparam int AM_BIT = 6;
	localparam int CI_BIT = 5;
	localparam int SC_BIT = 4;
	localparam int SD_BIT = 3;
	localparam int UC_BIT = 2;
	localparam int UD_BIT = 1;
	localparam int VALID_BIT = 0;
	localparam logic [31:0] MASK_WR_BITS = 32'hFFFF_017F;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Origin and control register layout and reset values
	// ------------------------------------------------------------
	localparam int ORIGIN_LSB = 16;
	localparam logic [31:0] ORIGIN_RESET = 32'h0000_0000;
	localparam logic [15:0] CONTROL_WR_BITS = 16'h3DF8;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] BOOT_CONTROL_RESET = 16'h3D80;

	// ------------------------------------------------------------
	// Access space codes presented with each access
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SPACE_CPU = 3'h0,
		SPACE_SUP_CODE = 3'h1,
		SPACE_SUP_DATA = 3'h2,
		SPACE_USER_CODE = 3'h3,
		SPACE_USER_DATA = 3'h4
	} space_e;
endpackage

// ===== logic/bank_match.sv
// One bank's address, space, protect and valid qualifier
`timescale 1ns/100ps
module bank_match
	import cs_decode_pkg::*;
#(
	parameter bit IS_BOOT = 1'b0
) (
	input wire logic [31:0] origin,
	input wire logic [31:0] mask,
	input wire logic [31:0] accAddr,
	input wire logic accWrite,
	input wire logic accDma,
	input wire logic [2:0] accSpace,
	input wire logic bootGlobal,
	output logic hit,
	output logic select
);
	logic [15:0] careBits;
	logic addrHit;
	logic spaceBlock;
	logic spaceFree;
	logic wpBlock;
	logic bankOn;

	// Address compare on upper bits, ignore bits drop out
	assign careBits = ~mask[IGN_LSB +: IGN_W];
	assign addrHit = ((accAddr[31:16] ^ origin[ORIGIN_LSB +: 16])
		& careBits) == 16'h0000;

	// Space block bit for this access type
	always_comb begin
		unique case (accSpace)
			SPACE_CPU: spaceBlock = mask[CI_BIT];
			SPACE_SUP_CODE: spaceBlock = mask[SC_BIT];
			SPACE_SUP_DATA: spaceBlock = mask[SD_BIT];
			SPACE_USER_CODE: spaceBlock = mask[UC_BIT];
			SPACE_USER_DATA: spaceBlock = mask[UD_BIT];
			default: spaceBlock = 1'b1;
		endcase
	end

	// DMA without other-master check skips code/data spaces
	assign spaceFree = (accDma && !mask[AM_BIT]
		&& accSpace != SPACE_CPU) || !spaceBlock;
	assign wpBlock = accWrite && mask[WP_BIT];
	assign bankOn = mask[VALID_BIT];

	assign hit = addrHit;
	// Boot bank answers globally until first made valid
	assign select = (IS_BOOT && bootGlobal)
		|| (addrHit && spaceFree && !wpBlock && bankOn);
endmodule

// ===== logic/chip_select_mask_decode.sv
// Chip-select decode qualifier with its register file
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module chip_select_mask_decode
	import cs_decode_pkg::*;
#(
	parameter int BANKS = NUM_BANKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic accValid,
	input wire logic [31:0] accAddr,
	input wire logic accWrite,
	input wire logic accDma,
	input wire logic [2:0] accSpace,
	output logic [BANKS-1:0] bankSelect,
	output logic externalCycle,
	output logic [BANKS-1:0] bankControl0,
	output logic [15:0] selControl
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (BANKS < 4 || BANKS > NUM_BANKS) begin : g_bad_banks
		$error("BANKS out of range");
	end

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [31:0] origin_q [BANKS];
	logic [31:0] origin_d [BANKS];
	logic [31:0] mask_q [BANKS];
	logic [31:0] mask_d [BANKS];
	logic [15:0] control_q [BANKS];
	logic [15:0] control_d [BANKS];
	logic bootGlobal_q;
	logic bootGlobal_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [BANKS-1:0] sel_q;
	logic [BANKS-1:0] sel_d;
	logic ext_q;
	logic ext_d;
	logic [15:0] selCtl_q;
	logic [15:0] selCtl_d;
	logic [BANKS-1:0] hitRaw;
	logic [BANKS-1:0] selRaw;
	logic [BANKS-1:0] lastHit_q;
	logic [BANKS-1:0] lastHit_d;

	// Per-bank qualifiers
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		bank_match #(
			.IS_BOOT(b == 0)
		) u_match (
			.origin(origin_q[b]),
			.mask(mask_q[b]),
			.accAddr(accAddr),
			.accWrite(accWrite),
			.accDma(accDma),
			.accSpace(accSpace),
			.bootGlobal(bootGlobal_q),
			.hit(hitRaw[b]),
			.select(selRaw[b])
		);
	end

	// ------------------------------------------------------------
	// Register writes and boot global state
	// ------------------------------------------------------------
	// Next values of the bank registers on a write
	always_comb begin
		logic [7:0] base;
		base = 8'h00;
		bootGlobal_d = bootGlobal_q;
		for (int b = 0; b < BANKS; b++) begin
			base = ORIGIN_BASE + 8'(b) * BANK_STRIDE;
			origin_d[b] = origin_q[b];
			mask_d[b] = mask_q[b];
			control_d[b] = control_q[b];
			if (regWrite && regAddr == base) begin
				origin_d[b] = {regWdata[31:16], 16'h0000};
			end
			if (regWrite && regAddr == base + MASK_OFS) begin
				mask_d[b] = regWdata & MASK_WR_BITS;
				// Boot bank leaves global mode once validated
				if (b == 0 && regWdata[VALID_BIT]) begin
					bootGlobal_d = 1'b0;
				end
			end
			if (regWrite && regAddr == base + CONTROL_OFS) begin
				control_d[b] = regWdata[15:0] & CONTROL_WR_BITS;
			end
		end
	end

	// Bank registers, boot bank with its own control reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < BANKS; b++) begin
				origin_q[b] <= ORIGIN_RESET;
				mask_q[b] <= MASK_RESET;
				control_q[b] <= (b == 0) ? BOOT_CONTROL_RESET
					: CONTROL_RESET;
			end
			bootGlobal_q <= 1'b1;
		end else begin
			origin_q <= origin_d;
			mask_q <= mask_d;
			control_q <= control_d;
			bootGlobal_q <= bootGlobal_d;
		end
	end

	// ------------------------------------------------------------
	// Register reads, data one cycle after the strobe
	// ------------------------------------------------------------
	// Read mux, zero when no read strobe
	always_comb begin
		logic [7:0] base;
		base = 8'h00;
		rdata_d = 32'h0000_0000;
		if (regRead) begin
			for (int b = 0; b < BANKS; b++) begin
				base = ORIGIN_BASE + 8'(b) * BANK_STRIDE;
				if (regAddr == base) begin
					rdata_d = origin_q[b];
				end
				if (regAddr == base + MASK_OFS) begin
					rdata_d = mask_q[b];
				end
				if (regAddr == base + CONTROL_OFS) begin
					rdata_d = {16'h0000, control_q[b]};
				end
			end
			if (regAddr == STATUS_OFS) begin
				rdata_d = {15'h0000, bootGlobal_q, 16'(lastHit_q)};
			end
		end
	end

	// ------------------------------------------------------------
	// Decode outputs, registered one cycle after the access
	// ------------------------------------------------------------
	// Select decode, ordinary cycle when nothing selects
	always_comb begin
		sel_d = '0;
		ext_d = 1'b0;
		selCtl_d = 16'h0000;
		lastHit_d = lastHit_q;
		if (accValid) begin
			// Lowest numbered selecting bank wins
			for (int b = BANKS - 1; b >= 0; b--) begin
				if (selRaw[b]) begin
					sel_d = '0;
					sel_d[b] = 1'b1;
					selCtl_d = control_q[b];
				end
			end
			ext_d = (sel_d == '0);
			lastHit_d = hitRaw;
		end
	end

	// Output registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
			sel_q <= '0;
			ext_q <= 1'b0;
			selCtl_q <= 16'h0000;
			lastHit_q <= '0;
		end else begin
			rdata_q <= rdata_d;
			sel_q <= sel_d;
			ext_q <= ext_d;
			selCtl_q <= selCtl_d;
			lastHit_q <= lastHit_d;
		end
	end

	// Outputs straight from registers
	assign regRdata = rdata_q;
	assign bankSelect = sel_q;
	assign externalCycle = ext_q;
	assign selControl = selCtl_q;
	assign bankControl0 = BANKS'(control_q[0]);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_wp_no_write: assert property (@(posedge clk) disable iff (rst)
		accValid && accWrite && mask_q[1][WP_BIT] && !bootGlobal_q
		|=> !bankSelect[1])
		else $error("protected bank selected on write");

	a_invalid_quiet: assert property (@(posedge clk) disable iff (rst)
		accValid && !mask_q[2][VALID_BIT] |=> !bankSelect[2])
		else $error("invalid bank selected");

	a_valid_reset: assert property (@(posedge clk)
		$fell(rst) |-> mask_q[3][VALID_BIT] == 1'b0)
		else $error("valid bit not cleared by reset");

	a_boot_global: assert property (@(posedge clk) disable iff (rst)
		accValid && bootGlobal_q |=> bankSelect[0] && !externalCycle)
		else $error("boot bank not global after reset");

	a_boot_ctrl: assert property (@(posedge clk)
		$fell(rst) |-> control_q[0] == BOOT_CONTROL_RESET)
		else $error("boot control reset wrong");

	a_one_hot: assert property (@(posedge clk) disable iff (rst)
		$onehot0(bankSelect) && (externalCycle -> bankSelect == '0))
		else $error("select not one-hot");

	a_ext_miss: assert property (@(posedge clk) disable iff (rst)
		accValid && selRaw == '0 |=> externalCycle)
		else $error("no external cycle on miss");

	a_addr_miss: assert property (@(posedge clk) disable iff (rst)
		accValid && !hitRaw[1] && !bootGlobal_q |=> !bankSelect[1])
		else $error("select without address match");

	a_read_ok: assert property (@(posedge clk) disable iff (rst)
		accValid && !accWrite && !bootGlobal_q && selRaw[0]
		|=> bankSelect[0])
		else $error("read blocked on selecting bank");

	a_wp_read_pass: assert property (@(posedge clk) disable iff (rst)
		accValid && !accWrite && mask_q[1][WP_BIT] && selRaw[1]
		&& !selRaw[0] |=> bankSelect[1])
		else $error("protected bank refused a read");

	a_open_write: assert property (@(posedge clk) disable iff (rst)
		accValid && accWrite && !accDma && !bootGlobal_q && !selRaw[0]
		&& hitRaw[1] && mask_q[1][VALID_BIT] && !mask_q[1][WP_BIT]
		&& accSpace == SPACE_USER_DATA && !mask_q[1][UD_BIT]
		|=> bankSelect[1])
		else $error("open bank refused a write");

	a_dma_space: assert property (@(posedge clk) disable iff (rst)
		accValid && accDma && !mask_q[1][AM_BIT] && !bootGlobal_q
		&& accSpace != SPACE_CPU && accSpace <= SPACE_USER_DATA
		&& hitRaw[1] && mask_q[1][VALID_BIT] && !selRaw[0]
		&& (!accWrite || !mask_q[1][WP_BIT]) |=> bankSelect[1])
		else $error("DMA access blocked by a code or data bit");

	a_cpu_block: assert property (@(posedge clk) disable iff (rst)
		accValid && accSpace == SPACE_CPU && mask_q[1][CI_BIT]
		|=> !bankSelect[1])
		else $error("CPU space access not blocked");

	a_user_block: assert property (@(posedge clk) disable iff (rst)
		accValid && !accDma && accSpace == SPACE_USER_DATA
		&& mask_q[1][UD_BIT] |=> !bankSelect[1])
		else $error("user data access not blocked");

	a_space_block: assert property (@(posedge clk) disable iff (rst)
		accValid && !accDma && accSpace == SPACE_SUP_CODE
		&& mask_q[1][SC_BIT] |=> !bankSelect[1])
		else $error("supervisor code access not blocked");

	a_bad_space: assert property (@(posedge clk) disable iff (rst)
		accValid && !accDma && !bootGlobal_q
		&& accSpace > SPACE_USER_DATA |=> externalCycle)
		else $error("unknown space code selected a bank");

	a_valid_needed: assert property (@(posedge clk) disable iff (rst)
		accValid && !mask_q[1][VALID_BIT] |=> !bankSelect[1])
		else $error("invalid bank one selected");

	a_invalid_three: assert property (@(posedge clk) disable iff (rst)
		accValid && !mask_q[3][VALID_BIT] |=> !bankSelect[3])
		else $error("invalid bank three selected");

	a_boot_leave: assert property (@(posedge clk) disable iff (rst)
		regWrite && regAddr == ORIGIN_BASE + MASK_OFS
		&& regWdata[VALID_BIT] |=> !bootGlobal_q)
		else $error("boot bank kept global after validation");

	a_boot_stay: assert property (@(posedge clk) disable iff (rst)
		bootGlobal_q && !(regWrite && regAddr == ORIGIN_BASE + MASK_OFS
		&& regWdata[VALID_BIT]) |=> bootGlobal_q)
		else $error("boot bank left global mode early");

	a_global_reset: assert property (@(posedge clk)
		$fell(rst) |-> bootGlobal_q)
		else $error("global mode not set by reset");

	a_out_reset: assert property (@(posedge clk)
		$fell(rst) |-> bankSelect == '0 && !externalCycle
		&& regRdata == 32'h0000_0000)
		else $error("outputs not quiet after reset");

	a_mask_reset: assert property (@(posedge clk)
		$fell(rst) |-> !mask_q[0][VALID_BIT] && !mask_q[1][VALID_BIT]
		&& !mask_q[2][VALID_BIT])
		else $error("valid bits not cleared by reset");

	a_ctrl_reset: assert property (@(posedge clk)
		$fell(rst) |-> control_q[1] == CONTROL_RESET)
		else $error("bank control reset wrong");

	a_mask_write: assert property (@(posedge clk) disable iff (rst)
		regWrite && regAddr == ORIGIN_BASE + BANK_STRIDE + MASK_OFS
		|=> mask_q[1] == ($past(regWdata) & MASK_WR_BITS))
		else $error("mask write not stored");

	a_origin_write: assert property (@(posedge clk) disable iff (rst)
		regWrite && regAddr == ORIGIN_BASE
		|=> origin_q[0] == ($past(regWdata) & 32'hFFFF_0000))
		else $error("origin write not stored");

	a_mask_read: assert property (@(posedge clk) disable iff (rst)
		regRead && regAddr == ORIGIN_BASE + MASK_OFS
		|=> regRdata == $past(mask_q[0]))
		else $error("mask read data wrong");

	a_sel_control: assert property (@(posedge clk) disable iff (rst)
		accValid && bootGlobal_q |=> selControl == $past(control_q[0]))
		else $error("boot control not presented");

	a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
		!accValid |=> bankSelect == '0 && !externalCycle)
		else $error("select without an access");

	a_miss_all: assert property (@(posedge clk) disable iff (rst)
		accValid && !bootGlobal_q && hitRaw == '0 |=> externalCycle)
		else $error("miss without ordinary cycle");

	a_size_limit: assert property (@(posedge clk) disable iff (rst)
		accValid && mask_q[1][IGN_LSB +: IGN_W] == 16'h0003
		&& accAddr[31:18] != origin_q[1][31:18] |=> !bankSelect[1])
		else $error("select outside bank size");
endmodule

// ===== verification/ext_bus_model.sv
// Far-side bus model watching chip selects and ordinary cycles
`timescale 1ns/100ps
module ext_bus_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [6:0] bankSelect,
	input wire logic externalCycle,
	output logic clash
);
	logic clash_q;
	logic clash_d;
	// Two selects, or a select beside an ordinary cycle, is a clash
	always_comb begin
		clash_d = clash_q;
		if (!$onehot0({externalCycle, bankSelect})) begin
			clash_d = 1'b1;
		end
	end
	// Sticky clash flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clash_q <= 1'b0;
		end else begin
			clash_q <= clash_d;
		end
	end
	assign clash = clash_q;
endmodule

// ===== verification/tb.sv
// Self-checking bench for the chip-select decode block
`timescale 1ns/100ps
module tb;
	import cs_decode_pkg::*;
	logic clk, rst, regWrite, regRead, accValid, accWrite, accDma, clash;
	logic externalCycle;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, accAddr;
	logic [2:0] accSpace;
	logic [6:0] bankSelect, bankControl0;
	logic [15:0] selControl;
	int errTotal = 0;
	int checked = 0;
	int cycles = 0;
	chip_select_mask_decode u_dut (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .accValid(accValid), .accAddr(accAddr),
		.accWrite(accWrite), .accDma(accDma), .accSpace(accSpace),
		.bankSelect(bankSelect), .externalCycle(externalCycle),
		.bankControl0(bankControl0), .selControl(selControl));
	ext_bus_model u_bus (.clk(clk), .rst(rst), .bankSelect(bankSelect),
		.externalCycle(externalCycle), .clash(clash));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errTotal++;
			test_done();
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] ofs(int b, logic [7:0] o);
		return ORIGIN_BASE + BANK_STRIDE * 8'(b) + o;
	endfunction
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(string n, logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(n, e, regRdata);
	endtask
	// One access; expected selects, ordinary cycle when none
	task automatic acc(string n, logic [31:0] a, logic w, logic d,
		logic [2:0] s, logic [6:0] e);
		@(posedge clk);
		accValid <= 1'b1;
		accAddr <= a;
		accWrite <= w;
		accDma <= d;
		accSpace <= s;
		@(posedge clk);
		accValid <= 1'b0;
		#1 chk(n, {e == 7'h00, e}, {externalCycle, bankSelect});
	endtask
	task automatic test_boot();
		for (int b = 0; b < 7; b++) begin
			rd("mask reset", ofs(b, MASK_OFS), 32'h0000_0000);
		end
		rd("boot control", ofs(0, CONTROL_OFS), 32'h0000_3D80);
		rd("bank1 control", ofs(1, CONTROL_OFS), 32'h0000_0000);
		acc("boot global", 32'h9ABC_0000, 1'b1, 1'b0, 3'h4, 7'h01);
		chk("boot sel control", 32'h0000_3D80, {16'h0000, selControl});
		wr(ofs(0, 8'h00), 32'h0000_0000);
		wr(ofs(0, MASK_OFS), 32'h0000_0001);
		acc("boot out", 32'h0001_0000, 1'b0, 1'b0, 3'h1, 7'h00);
		acc("boot in", 32'h0000_FFFC, 1'b0, 1'b0, 3'h1, 7'h01);
		$display("test_boot done");
	endtask
	task automatic test_size();
		wr(ofs(1, 8'h00), 32'h1000_0000);
		wr(ofs(1, MASK_OFS), 32'h0003_0001);
		acc("top of bank", 32'h1003_FFFC, 1'b0, 1'b0, 3'h2, 7'h02);
		acc("past bank", 32'h1004_0000, 1'b0, 1'b0, 3'h2, 7'h00);
		acc("ignored bit", 32'h1001_0000, 1'b1, 1'b0, 3'h2, 7'h02);
		acc("high bit", 32'h9001_0000, 1'b0, 1'b0, 3'h2, 7'h00);
		$display("test_size done");
	endtask
	task automatic test_protect();
		wr(ofs(1, MASK_OFS), 32'h0003_0101);
		acc("wp write", 32'h1000_0010, 1'b1, 1'b0, 3'h4, 7'h00);
		acc("wp read", 32'h1000_0010, 1'b0, 1'b0, 3'h4, 7'h02);
		wr(ofs(1, MASK_OFS), 32'h0003_0001);
		acc("open write", 32'h1000_0010, 1'b1, 1'b0, 3'h4, 7'h02);
		$display("test_protect done");
	endtask
	task automatic test_space();
		logic [2:0] o;
		for (int s = 0; s < 5; s++) begin
			o = 3'((s + 1) % 5);
			wr(ofs(1, MASK_OFS), 32'h0003_0001 | (32'h1 << (5 - s)));
			acc("blocked", 32'h1000_0000, 1'b0, 1'b0, 3'(s), 7'h00);
			acc("other open", 32'h1000_0000, 1'b0, 1'b0, o, 7'h02);
		end
		wr(ofs(1, MASK_OFS), 32'h0003_0011);
		acc("dma am0", 32'h1000_0000, 1'b0, 1'b1, 3'h1, 7'h02);
		wr(ofs(1, MASK_OFS), 32'h0003_0051);
		acc("dma am1", 32'h1000_0000, 1'b0, 1'b1, 3'h1, 7'h00);
		acc("bad space", 32'h1000_0000, 1'b0, 1'b0, 3'h5, 7'h00);
		$display("test_space done");
	endtask
	task automatic test_valid();
		wr(ofs(2, 8'h00), 32'h2000_0000);
		wr(ofs(2, MASK_OFS), 32'hFFFF_FFFE);
		rd("mask writable", ofs(2, MASK_OFS), 32'hFFFF_017E);
		wr(ofs(2, MASK_OFS), 32'h0000_0000);
		acc("not valid", 32'h2000_0000, 1'b0, 1'b0, 3'h2, 7'h00);
		rd("unmapped", 8'hF0, 32'h0000_0000);
		wr(ofs(2, MASK_OFS), 32'h0000_0001);
		acc("now valid", 32'h2000_0000, 1'b0, 1'b0, 3'h2, 7'h04);
		$display("test_valid done");
	endtask
	task automatic test_reset();
		wr(ofs(0, CONTROL_OFS), 32'hFFFF_FFFF);
		rd("ctl writable", ofs(0, CONTROL_OFS), 32'h0000_3DF8);
		chk("ctl low bits", 32'h0000_0078, {25'h0, bankControl0});
		chk("clash before reset", 32'h0, {31'h0, clash});
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int b = 0; b < 7; b++) begin
			rd("mask cleared", ofs(b, MASK_OFS), 32'h0);
		end
		rd("ctl after reset", ofs(0, CONTROL_OFS), 32'h0000_3D80);
		rd("status after reset", STATUS_OFS, 32'h0001_0000);
		acc("global again", 32'h2000_0000, 1'b1, 1'b0, 3'h2, 7'h01);
		chk("ctl on select", 32'h0000_3D80, {16'h0, selControl});
		$display("test_reset done");
	endtask
	task automatic test_done();
		chk("bus clash", 32'h0, {31'h0, clash});
		$display("comparisons %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		{regWrite, regRead, accValid, accWrite, accDma} = 5'h00;
		regAddr = 8'h00;
		regWdata = 32'h0000_0000;
		accAddr = 32'h0000_0000;
		accSpace = 3'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		test_boot();
		test_size();
		test_protect();
		test_space();
		test_valid();
		test_reset();
		test_done();
	end
endmodule
